// ===== hdl/ssp_params.svh
// constants for the serial slave port and its master end
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_CTRL_OFS 4'h0
`define SSP_DATA_OFS 4'h4
`define SSP_CFG_OFS 4'h8
`define SSP_RATE_OFS 4'hc
`define SSP_MST_CMD_OFS 4'h0
`define SSP_MST_STAT_OFS 4'h4
`define SSP_MST_CFG_OFS 4'h8
`define SSP_CTL_BYTE_DONE 7
`define SSP_CTL_WRITE_COLLISION_FLAG 6
`define SSP_CTL_MODE_FAULT_FLAG 5
`define SSP_CTL_RXOVR 4
`define SSP_CTL_SEL_HI 3
`define SSP_CTL_SEL_LO 2
`define SSP_CTL_MST_EN 1
`define SSP_CTL_PORT_EN 0
`define SSP_CFG_MULTI 6
`define SSP_CFG_PHASE 5
`define SSP_CFG_POL 4
`define SSP_CTRL_RESET 8'h04
`define SSP_CFG_RESET 8'h00
`define SSP_BITS 4'h8
`define SSP_SEL_LEAD_CLKS 2
`define SSP_MST_HALF_DIV 8'h08
`endif

// ===== hdl/ssp_pkg.sv
// types used by the master end of the serial slave port
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_M_IDLE = 2'b00,
    SSP_M_LEAD = 2'b01,
    SSP_M_SHIFT = 2'b11,
    SSP_M_TAIL = 2'b10
  } ssp_mst_state_t;
endpackage

// ===== hdl/ssp_link_if.sv
// link wires between the serial slave port and its master
`timescale 1ns/10ps
`default_nettype none
interface ssp_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic slave_select_n;
  modport slave (input sck, input mosi, input slave_select_n, output miso, output miso_oe);
  modport master (output sck, output mosi, output slave_select_n, input miso, input miso_oe);
endinterface
`default_nettype wire

// ===== hdl/ssp_slave.sv
// serial slave port: device end with wishbone register file
//
// Summary of operation
// - enabled non-master port acts only as slave
// - eight sck cycles set done, load receive buffer
// - data read returns receive buffer
// - write buffers byte, loads empty shifter immediately
// - otherwise load after last edge of transfer
// - select mode 01 is four-wire default
// - four-wire: active only while select low
// - select falling edge clears bit counter
// - master lowers select two half periods (16 clocks) early
// - select mode 00 ignores select pin
// - three-wire counter reset only by re-enable
// - three-wire bus holds only this slave
// - flags are sticky, cleared only by software
// - byte done flag bit 7 every byte
// - write while buffer full sets collision, dropped
// - selected master sets fault, clears enables
// - overrun keeps old byte, drops new one
// - phase bit 5, polarity bit 4
// - master uses same phase and polarity
// - disable port before changing clock mode
// - rate register ignored in slave mode
// - master bit rate at most clock/10
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_slave (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link
  ssp_link_if.slave link
);
  import ssp_pkg::*;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] mosi_s;
    logic [2:0] sel_s;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] shreg;
    logic [7:0] txbuf;
    logic tx_full;
    logic sh_loaded;
    logic [7:0] rxbuf;
    logic rx_full;
    logic [3:0] bitcnt;
    logic sample;
    logic miso;
    logic miso_oe;
    logic ack;
    logic [31:0] rdata;
  } ssp_slv_state_t;

  ssp_slv_state_t st_reg;
  ssp_slv_state_t st_next;

  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic sel_fall;
  logic four_wire;
  logic active;
  logic wr;
  logic rd;

  always_comb begin
    st_next = st_reg;
    // first stage only feeds second; edges compare stages two and three
    st_next.sck_s = {st_reg.sck_s[1:0], link.sck};
    st_next.mosi_s = {st_reg.mosi_s[1:0], link.mosi};
    st_next.sel_s = {st_reg.sel_s[1:0], link.slave_select_n};
    sck_rise = st_reg.sck_s[1] & ~st_reg.sck_s[2];
    sck_fall = ~st_reg.sck_s[1] & st_reg.sck_s[2];
    sel_fall = ~st_reg.sel_s[1] & st_reg.sel_s[2];
    // idle level given by polarity; leading edge leaves idle
    lead_edge = st_reg.cfg[`SSP_CFG_POL] ? sck_fall : sck_rise;
    trail_edge = st_reg.cfg[`SSP_CFG_POL] ? sck_rise : sck_fall;
    sample_edge = st_reg.cfg[`SSP_CFG_PHASE] ? trail_edge : lead_edge;
    shift_edge = st_reg.cfg[`SSP_CFG_PHASE] ? lead_edge : trail_edge;
    four_wire = ~st_reg.ctrl[`SSP_CTL_SEL_HI] & st_reg.ctrl[`SSP_CTL_SEL_LO];
    // mode 00 leaves select out entirely
    active = st_reg.ctrl[`SSP_CTL_PORT_EN] & ~st_reg.ctrl[`SSP_CTL_MST_EN]
      & (~four_wire | ~st_reg.sel_s[2]);
    // write lands on the edge where the master sees ack
    wr = cyc_i & stb_i & we_i & st_reg.ack & sel_i[0];
    rd = cyc_i & stb_i & ~we_i & ~st_reg.ack;

    st_next.ack = cyc_i & stb_i & ~st_reg.ack;
    st_next.rdata = 32'h0;
    st_next.miso_oe = four_wire ? active : st_reg.ctrl[`SSP_CTL_PORT_EN];

    if (~st_reg.ctrl[`SSP_CTL_PORT_EN]) begin
      st_next.bitcnt = 4'h0;
      st_next.sh_loaded = 1'b0;
    end else if (four_wire && sel_fall) begin
      st_next.bitcnt = 4'h0;
    end
    if (st_reg.ctrl[`SSP_CTL_MST_EN] && st_reg.cfg[`SSP_CFG_MULTI]
        && four_wire && ~st_reg.sel_s[2]) begin
      st_next.ctrl[`SSP_CTL_MODE_FAULT_FLAG] = 1'b1;
      st_next.ctrl[`SSP_CTL_MST_EN] = 1'b0;
      st_next.ctrl[`SSP_CTL_PORT_EN] = 1'b0;
    end

    // in phase 0 the first bit must be on miso before the first edge
    if (st_reg.cfg[`SSP_CFG_PHASE] == 1'b0 && st_reg.bitcnt == 4'h0) begin
      st_next.miso = st_reg.shreg[7];
    end
    if (active && sample_edge) begin
      st_next.sample = st_reg.mosi_s[2];
      st_next.bitcnt = st_reg.bitcnt + 4'h1;
      if (st_reg.cfg[`SSP_CFG_PHASE]) begin
        st_next.shreg = {st_reg.shreg[6:0], st_reg.mosi_s[2]};
      end
    end
    if (active && shift_edge && st_reg.bitcnt != 4'h0) begin
      if (st_reg.cfg[`SSP_CFG_PHASE] == 1'b0) begin
        st_next.shreg = {st_reg.shreg[6:0], st_reg.sample};
        st_next.miso = st_reg.shreg[6];
      end
    end else if (active && shift_edge && st_reg.cfg[`SSP_CFG_PHASE]) begin
      st_next.miso = st_reg.shreg[7];
    end
    if (active && shift_edge && st_reg.cfg[`SSP_CFG_PHASE] && st_reg.bitcnt != 4'h0) begin
      st_next.miso = st_reg.shreg[7];
    end

    // byte end: phase 1 one clock after last sample edge, phase 0 on the shift after it
    if (st_reg.bitcnt == `SSP_BITS
        && (st_reg.cfg[`SSP_CFG_PHASE] || (active && shift_edge))) begin
      st_next.bitcnt = 4'h0;
      st_next.sh_loaded = 1'b0;
      st_next.ctrl[`SSP_CTL_BYTE_DONE] = 1'b1;
      if (st_reg.rx_full) begin
        st_next.ctrl[`SSP_CTL_RXOVR] = 1'b1;
      end else begin
        st_next.rxbuf = st_reg.cfg[`SSP_CFG_PHASE] ? st_reg.shreg
          : {st_reg.shreg[6:0], st_reg.sample};
        st_next.rx_full = 1'b1;
      end
    end

    // transmit buffer moves over while no byte is in flight
    if (st_reg.tx_full && !st_next.sh_loaded && st_next.bitcnt == 4'h0) begin
      st_next.shreg = st_reg.txbuf;
      st_next.tx_full = 1'b0;
      st_next.sh_loaded = 1'b1;
      st_next.miso = st_reg.txbuf[7];
    end

    if (wr) begin
      case (adr_i)
        `SSP_CTRL_OFS: begin
          // flags are write-zero-to-clear; set in same cycle wins
          st_next.ctrl[3:0] = dat_i[3:0];
          st_next.ctrl[7:4] = st_next.ctrl[7:4] & (dat_i[7:4] | (st_next.ctrl[7:4]
            & ~st_reg.ctrl[7:4]));
        end
        `SSP_DATA_OFS: begin
          if (st_reg.tx_full) begin
            st_next.ctrl[`SSP_CTL_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            st_next.txbuf = dat_i[7:0];
            st_next.tx_full = 1'b1;
          end
        end
        `SSP_CFG_OFS: st_next.cfg = dat_i[7:0];
        `SSP_RATE_OFS: st_next.rate = dat_i[7:0];
        default: st_next.rate = st_reg.rate;
      endcase
    end
    if (rd) begin
      case (adr_i)
        `SSP_CTRL_OFS: st_next.rdata = {24'h0, st_reg.ctrl};
        `SSP_DATA_OFS: begin
          st_next.rdata = {24'h0, st_reg.rxbuf};
          st_next.rx_full = st_next.rx_full & ~st_reg.rx_full;
        end
        `SSP_CFG_OFS: st_next.rdata = {24'h0, st_reg.cfg};
        `SSP_RATE_OFS: st_next.rdata = {24'h0, st_reg.rate};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.sck_s <= 3'h0;
      st_reg.sel_s <= 3'h7;
      st_reg.ctrl <= `SSP_CTRL_RESET;
      st_reg.cfg <= `SSP_CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dat_o = st_reg.rdata;
  assign ack_o = st_reg.ack;
  assign link.miso = st_reg.miso;
  assign link.miso_oe = st_reg.miso_oe;
endmodule
`default_nettype wire

// ===== hdl/ssp_master.sv
// serial slave port: master end driving the link
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_master #(
  parameter logic [7:0] HALF_DIV = `SSP_MST_HALF_DIV
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link
  ssp_link_if.master link
);
  import ssp_pkg::*;

  typedef struct packed {
    ssp_mst_state_t fsm;
    logic [2:0] miso_s;
    logic [7:0] div;
    logic [3:0] bits;
    logic half;
    logic [7:0] tx;
    logic [7:0] rx;
    logic done;
    logic pha;
    logic pol;
    logic keep_sel;
    logic sck;
    logic mosi;
    logic sel_n;
    logic ack;
    logic [31:0] rdata;
  } ssp_mst_reg_t;

  ssp_mst_reg_t st_reg;
  ssp_mst_reg_t st_next;
  logic tick;
  logic wr;

  always_comb begin
    st_next = st_reg;
    st_next.miso_s = {st_reg.miso_s[1:0], link.miso};
    tick = st_reg.div == 8'h0;
    st_next.div = tick ? HALF_DIV - 8'h1 : st_reg.div - 8'h1;
    // write lands on the edge where the bus master sees ack
    wr = cyc_i & stb_i & we_i & st_reg.ack & sel_i[0];
    st_next.ack = cyc_i & stb_i & ~st_reg.ack;
    st_next.rdata = 32'h0;
    case (st_reg.fsm)
      SSP_M_IDLE: begin
        st_next.sck = st_reg.pol;
        st_next.sel_n = ~st_reg.keep_sel;
        if (wr && adr_i == `SSP_MST_CMD_OFS) begin
          st_next.tx = dat_i[7:0];
          st_next.sel_n = 1'b0;
          st_next.done = 1'b0;
          st_next.bits = 4'h0;
          st_next.half = 1'b0;
          st_next.mosi = dat_i[7];
          st_next.div = HALF_DIV - 8'h1;
          st_next.fsm = SSP_M_LEAD;
        end
      end
      // select leads first edge by two half periods, above two clocks
      SSP_M_LEAD: if (tick) st_next.fsm = SSP_M_SHIFT;
      SSP_M_SHIFT: begin
        if (tick) begin
          st_next.sck = ~st_reg.sck;
          st_next.half = ~st_reg.half;
          if (!st_reg.half) begin
            if (st_reg.pha) begin
              st_next.mosi = st_reg.tx[7];
            end else begin
              st_next.rx = {st_reg.rx[6:0], st_reg.miso_s[2]};
            end
          end else begin
            if (st_reg.pha) begin
              st_next.rx = {st_reg.rx[6:0], st_reg.miso_s[2]};
              st_next.tx = {st_reg.tx[6:0], 1'b0};
            end else begin
              st_next.tx = {st_reg.tx[6:0], 1'b0};
              st_next.mosi = st_reg.tx[6];
            end
            st_next.bits = st_reg.bits + 4'h1;
            if (st_reg.bits == `SSP_BITS - 4'h1) begin
              st_next.fsm = SSP_M_TAIL;
            end
          end
        end
      end
      SSP_M_TAIL: begin
        if (tick) begin
          st_next.done = 1'b1;
          st_next.sel_n = ~st_reg.keep_sel;
          st_next.fsm = SSP_M_IDLE;
        end
      end
      default: st_next.fsm = SSP_M_IDLE;
    endcase
    if (wr && adr_i == `SSP_MST_CFG_OFS && st_reg.fsm == SSP_M_IDLE) begin
      st_next.pha = dat_i[`SSP_CFG_PHASE];
      st_next.pol = dat_i[`SSP_CFG_POL];
      st_next.keep_sel = dat_i[0];
    end
    if (cyc_i && stb_i && !we_i && !st_reg.ack) begin
      case (adr_i)
        `SSP_MST_STAT_OFS: st_next.rdata = {22'h0, st_reg.fsm != SSP_M_IDLE,
          st_reg.done, st_reg.rx};
        `SSP_MST_CFG_OFS: st_next.rdata = {26'h0, st_reg.pha, st_reg.pol, 3'h0,
          st_reg.keep_sel};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.fsm <= SSP_M_IDLE;
      st_reg.sel_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dat_o = st_reg.rdata;
  assign ack_o = st_reg.ack;
  assign link.sck = st_reg.sck;
  assign link.mosi = st_reg.mosi;
  assign link.slave_select_n = st_reg.sel_n;
endmodule
`default_nettype wire

// ===== test/ssp_link_props.sv
// link timing checks between the serial port master and slave ends
`timescale 1ns/10ps
`default_nettype none
module ssp_link_props (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic slave_select_n
);
  logic [4:0] edge_cnt_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cleared while deselected so every byte counts from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || slave_select_n) begin
      edge_cnt_reg <= 5'h00;
    end else if ($changed(sck)) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end
  sequence s_sck_quiet;
    $stable(sck) [*4];
  endsequence
  property p_lead;
    $fell(slave_select_n) |-> $stable(sck) [*2];
  endproperty
  property p_half_period;
    $changed(sck) && !slave_select_n |=> s_sck_quiet;
  endproperty
  property p_tail;
    $changed(sck) |=> (!$rose(slave_select_n)) [*3];
  endproperty
  property p_frame_len;
    $rose(slave_select_n) |-> edge_cnt_reg == 5'h10;
  endproperty
  property p_mosi_hold;
    $changed(mosi) && !slave_select_n |=> $stable(mosi) [*4];
  endproperty
  // oe may drop right after a last change, so a released line is fine
  property p_miso_hold;
    $changed(miso) && miso_oe |=> ($stable(miso) || !miso_oe) [*4];
  endproperty
  property p_oe_idle;
    slave_select_n [*8] |-> !miso_oe;
  endproperty
  property p_gap;
    $rose(slave_select_n) |=> slave_select_n [*2];
  endproperty
  a_lead: assert property (p_lead) else $error("sck moved right after select fell");
  a_half_period: assert property (p_half_period) else $error("sck too fast");
  a_tail: assert property (p_tail) else $error("select released right after sck");
  a_frame_len: assert property (p_frame_len) else $error("frame edge count wrong");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi changed too soon");
  a_miso_hold: assert property (p_miso_hold) else $error("miso changed too soon");
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
  a_gap: assert property (p_gap) else $error("select high too short");
endmodule
`default_nettype wire

// ===== test/tb_spi_slave_port.sv
// bench: master end drives the slave port over the shared link
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module tb_spi_slave_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] stb = 2'b00;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  wire [1:0] ack;
  wire [31:0] s_rd;
  wire [31:0] m_rd;
  int errors = 0;
  int tests_run = 0;
  ssp_link_if ssp_link_if_i ();
  ssp_slave ssp_slave_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(stb[0]), .stb_i(stb[0]),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(s_rd), .ack_o(ack[0]),
    .link(ssp_link_if_i.slave));
  ssp_master ssp_master_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(stb[1]), .stb_i(stb[1]),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(m_rd), .ack_o(ack[1]),
    .link(ssp_link_if_i.master));
  ssp_link_props ssp_link_props_i (.clk_i(clk_i), .rst_i(rst_i), .sck(ssp_link_if_i.sck),
    .mosi(ssp_link_if_i.mosi), .miso(ssp_link_if_i.miso), .miso_oe(ssp_link_if_i.miso_oe),
    .slave_select_n(ssp_link_if_i.slave_select_n));
  always #10 clk_i = ~clk_i;
  task automatic results;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // m selects the master end; request held until ack is seen at an edge
  task automatic wb(input bit m, input bit w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n = 0;
    stb[m] <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack[m] !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      $display("MISMATCH %0t bus request not answered", $time);
      results();
    end
    q = m ? m_rd : s_rd;
    stb <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wr(input bit m, input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(m, 1'b1, a, d, q);
  endtask
  task automatic rchk(input bit m, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(m, 1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [31:0] q;
    int n = 0;
    wb(1'b1, 1'b1, `SSP_MST_CMD_OFS, {24'h0, tx}, q);
    do begin
      wb(1'b1, 1'b0, `SSP_MST_STAT_OFS, 32'h0, q);
      n++;
    end while (q[9] !== 1'b0 && n < 200);
    if (n >= 200) begin
      errors++;
      $display("MISMATCH %0t link transfer did not finish", $time);
      results();
    end
    rx = q[7:0];
  endtask
  task automatic t_modes;
    logic [7:0] tx;
    logic [7:0] rx;
    for (int m = 0; m < 4; m++) begin
      tx = 8'h96 ^ {4{m[1:0]}};
      wr(0, `SSP_CTRL_OFS, 32'h04);
      if (m > 0) rchk(0, `SSP_CTRL_OFS, 32'h04);
      wr(0, `SSP_CFG_OFS, {26'h0, m[1:0], 4'h0});
      wr(1, `SSP_MST_CFG_OFS, {26'h0, m[1:0], 4'h0});
      wr(0, `SSP_CTRL_OFS, 32'h05);
      wr(0, `SSP_DATA_OFS, {24'h0, ~tx});
      xfer(tx, rx);
      chk({24'h0, rx}, {24'h0, ~tx});
      rchk(0, `SSP_CTRL_OFS, 32'h85);
      rchk(0, `SSP_CTRL_OFS, 32'h85);
      rchk(0, `SSP_DATA_OFS, {24'h0, tx});
    end
  endtask
  // unread byte left in place so the second frame overruns
  task automatic t_collide;
    logic [7:0] rx;
    wr(0, `SSP_CTRL_OFS, 32'h05);
    wr(0, `SSP_DATA_OFS, 32'h11);
    wr(0, `SSP_DATA_OFS, 32'h22);
    wr(0, `SSP_DATA_OFS, 32'h33);
    rchk(0, `SSP_CTRL_OFS, 32'h45);
    xfer(8'h5a, rx);
    chk({24'h0, rx}, 32'h11);
    xfer(8'hc3, rx);
    chk({24'h0, rx}, 32'h22);
    rchk(0, `SSP_CTRL_OFS, 32'hd5);
    rchk(0, `SSP_DATA_OFS, 32'h5a);
  endtask
  task automatic t_fault;
    logic [7:0] rx;
    wr(0, `SSP_CTRL_OFS, 32'h04);
    wr(0, `SSP_CFG_OFS, 32'h40);
    wr(1, `SSP_MST_CFG_OFS, 32'h0);
    wr(0, `SSP_CTRL_OFS, 32'h07);
    xfer(8'h0f, rx);
    rchk(0, `SSP_CTRL_OFS, 32'h24);
    wr(0, `SSP_CTRL_OFS, 32'h04);
    wr(0, `SSP_CFG_OFS, 32'h0);
    xfer(8'h81, rx);
    rchk(0, `SSP_CTRL_OFS, 32'h04);
  endtask
  // select held low by the master and ignored by the slave
  task automatic t_three;
    logic [7:0] rx;
    wr(0, `SSP_CTRL_OFS, 32'h00);
    wr(1, `SSP_MST_CFG_OFS, 32'h01);
    wr(0, `SSP_CTRL_OFS, 32'h01);
    wr(0, `SSP_DATA_OFS, 32'h3c);
    xfer(8'hc5, rx);
    chk({24'h0, rx}, 32'h3c);
    rchk(0, `SSP_CTRL_OFS, 32'h81);
    rchk(0, `SSP_DATA_OFS, 32'hc5);
    // port off before select rises, so miso is released while idle
    wr(0, `SSP_CTRL_OFS, 32'h04);
    wr(1, `SSP_MST_CFG_OFS, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(0, `SSP_CTRL_OFS, 32'h04);
    rchk(0, `SSP_CFG_OFS, 32'h0);
    rchk(1, 4'hc, 32'h0);
    wr(0, `SSP_RATE_OFS, 32'hff);
    t_modes();
    t_collide();
    t_fault();
    t_three();
    results();
  end
  // about ten frames of some 200 clocks each, with wide margin
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
